// ### bb_pkg.sv
// Notes on behaviour
// RULE1: Read data buffered, returned to initiator bus.
// RULE2: Each write stays separate; never merged.
// RULE3: Order fixed at completion, not at retry.
// RULE4: Retried requests may complete in any order.
// RULE5: Initiators retry delayed requests fairly, independently.
// RULE6: Both directions post writes concurrently, independently.
// RULE7: Posted acceptance never waits on master completion.
// RULE8: Posted writes accepted regardless of delayed progress.
// RULE9: Posted writes complete in arrival order.
// RULE10: Delayed read waits for earlier posted writes.
// RULE11: Read completion waits for earlier posted writes.
// RULE12: Delayed write waits for earlier posted writes.
// RULE13: Fairness arbiter between posted and delayed queues.
// RULE14: Requests ordered, completions ordered; write completion passes.
// RULE15: Software reads back; no hardware flush exists.
// RULE16: Parity travels unchanged with address and data.
// RULE17: Address parity checked on both buses always.
// RULE18: Primary error with response set suppresses select.
// RULE19: Secondary error with response set suppresses select.
// RULE20: Detected parity bit set regardless of enables.
// RULE21: Primary error, both enables set, signals system error.
// RULE22: Secondary error, enables set, signals primary system error.
// RULE23: Delayed requests answered with retry and queued.
// RULE24: Arbiter priority alternates after each completion.
package bb_pkg;

  localparam int SEQ_W = 16;
  localparam int ADDR_W = 12;

  localparam logic [11:0] CTRL_OFF  = 12'h000;
  localparam logic [11:0] PSTAT_OFF = 12'h004;
  localparam logic [11:0] SSTAT_OFF = 12'h008;
  localparam logic [11:0] QSTAT_OFF = 12'h00c;

  localparam int CTRL_PRI_RESP = 0;
  localparam int CTRL_SERR_EN  = 1;
  localparam int CTRL_SEC_RESP = 2;
  localparam int STAT_DET      = 0;
  localparam int STAT_SSE      = 1;

  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic [1:0] {
    K_POSTED = 2'b00,
    K_DREAD  = 2'b01,
    K_DWRITE = 2'b10,
    K_NONE   = 2'b11
  } bb_kind_e;

  typedef enum logic {
    TS_IDLE = 1'b0,
    TS_BUSY = 1'b1
  } bb_tgt_e;

  typedef struct packed {
    bb_kind_e    kind;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
    logic        par;
  } bb_txn_s;

  typedef struct packed {
    bb_kind_e    kind;
    logic [31:0] data;
    logic        par;
  } bb_cpl_s;

endpackage

// ### bb_bridge_core.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module bb_bridge_core
  import bb_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        init_valid,
  input  bb_txn_s   [1:0]        init_txn,
  output logic      [1:0]        init_accept,
  output logic      [1:0]        init_retry,
  output logic      [1:0]        tgt_valid,
  output bb_txn_s   [1:0]        tgt_txn,
  input  wire logic [1:0]        tgt_done,
  input  wire logic [1:0]        tgt_retry,
  input  wire logic [1:0][31:0]  tgt_rdata,
  input  wire logic [1:0]        tgt_rpar,
  output logic      [1:0]        ret_valid,
  output bb_cpl_s   [1:0]        ret_cpl,
  input  wire logic [1:0]        ret_ack,
  input  wire logic [1:0]        pa_valid,
  input  wire logic [1:0][31:0]  pa_ad,
  input  wire logic [1:0][3:0]   pa_cbe,
  input  wire logic [1:0]        pa_par,
  input  wire logic [1:0]        pa_hit,
  output logic                   primary_device_select_n,
  output logic                   secondary_device_select_n,
  output logic                   primary_system_error_n
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [SEQ_W-1:0] DEPTH_S = SEQ_W'(DEPTH);

  logic [2:0]              ctrl_q;
  logic [1:0]              pstat_q;
  logic                    sstat_q;
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic [1:0]              devsel_n_q;
  logic                    serr_n_q;
  logic [1:0]              pa_err;
  logic [1:0]              pa_resp;
  logic [1:0]              serr_set;
  logic [1:0][SEQ_W-1:0]   pw_wp_all;
  logic [1:0][SEQ_W-1:0]   pw_rp_all;
  logic [1:0][SEQ_W-1:0]   pw_cnt_all;
  logic [1:0][SEQ_W-1:0]   dq_cnt_all;
  logic [1:0]              dq_gate_ok;
  logic [1:0]              cq_gate_ok;
  logic [1:0]              rr_all;
  logic [31:0]             rd_mux;
  logic                    map_hit;
  logic                    apb_wr;

  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;
  assign primary_device_select_n   = devsel_n_q[0];
  assign secondary_device_select_n = devsel_n_q[1];
  assign primary_system_error_n    = serr_n_q;

  // Register bus: each access answers in its first access-phase cycle.
  assign apb_wr = psel && penable && pready_q && pwrite;

  always_comb begin
    map_hit = 1'b1;
    rd_mux  = 32'h0;
    case (paddr)
      CTRL_OFF:  rd_mux = {29'h0, ctrl_q};
      PSTAT_OFF: rd_mux = {30'h0, pstat_q};
      SSTAT_OFF: rd_mux = {31'h0, sstat_q};
      QSTAT_OFF: rd_mux = {pw_cnt_all[1][7:0], pw_cnt_all[0][7:0],
                           dq_cnt_all[1][7:0], dq_cnt_all[0][7:0]};
      default:   map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !map_hit;
      prdata_q  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_wr && paddr == CTRL_OFF) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // Address parity on both buses; a new error wins over a clear.
  assign pa_resp[0] = ctrl_q[CTRL_PRI_RESP];
  assign pa_resp[1] = ctrl_q[CTRL_SEC_RESP];

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_bus
      assign pa_err[b] = pa_valid[b] && ^{pa_ad[b], pa_cbe[b], pa_par[b]}; // see RULE17
      assign serr_set[b] = pa_err[b] && pa_resp[b] && ctrl_q[CTRL_SERR_EN]; // see RULE21 see RULE22
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          devsel_n_q[b] <= 1'b1;
        end else begin
          devsel_n_q[b] <= !(pa_valid[b] && pa_hit[b] && !(pa_err[b] && pa_resp[b])); // see RULE18 see RULE19
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstat_q <= 2'h0;
      sstat_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == PSTAT_OFF) begin
        pstat_q <= pstat_q & ~pwdata[1:0];
      end
      if (apb_wr && paddr == SSTAT_OFF) begin
        sstat_q <= sstat_q & ~pwdata[0];
      end
      if (pa_err[0]) begin
        pstat_q[STAT_DET] <= 1'b1; // see RULE20
      end
      if (|serr_set) begin
        pstat_q[STAT_SSE] <= 1'b1; // see RULE21 see RULE22
      end
      if (pa_err[1]) begin
        sstat_q <= 1'b1; // see RULE20
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serr_n_q <= 1'b1;
    end else begin
      serr_n_q <= !(|serr_set); // see RULE21 see RULE22
    end
  end

  // One queue set per direction; directions share nothing but pointers.
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dir // see RULE6
      bb_txn_s          pw_mem [DEPTH];
      bb_txn_s          dq_mem [DEPTH];
      logic [SEQ_W-1:0] dq_tag [DEPTH];
      bb_cpl_s          cq_mem [DEPTH];
      logic [SEQ_W-1:0] cq_tag [DEPTH];
      logic [SEQ_W-1:0] pw_wp_q, pw_rp_q, dq_wp_q, dq_rp_q, cq_wp_q, cq_rp_q;
      logic [SEQ_W-1:0] dq_pass, cq_pass;
      logic             pw_push, dq_push, cq_push, pw_has, dq_elig;
      bb_tgt_e          state_q;
      logic             src_dly_q;
      logic             rr_q;
      bb_txn_s          dq_head;
      bb_cpl_s          cq_head;

      assign pw_wp_all[d]  = pw_wp_q;
      assign pw_rp_all[d]  = pw_rp_q;
      assign pw_cnt_all[d] = pw_wp_q - pw_rp_q;
      assign dq_cnt_all[d] = dq_wp_q - dq_rp_q;
      assign rr_all[d]     = rr_q;

      assign pw_push = init_valid[d] && init_txn[d].kind == K_POSTED
                       && pw_cnt_all[d] != DEPTH_S; // see RULE7 see RULE8
      assign dq_push = init_valid[d] && (init_txn[d].kind == K_DREAD
                       || init_txn[d].kind == K_DWRITE)
                       && dq_cnt_all[d] != DEPTH_S;
      assign pw_has  = pw_cnt_all[d] != '0;
      assign dq_head = dq_mem[dq_rp_q[AW-1:0]];
      assign cq_head = cq_mem[cq_rp_q[AW-1:0]];
      assign dq_pass = pw_rp_q - dq_tag[dq_rp_q[AW-1:0]];
      assign cq_pass = pw_rp_all[1-d] - cq_tag[cq_rp_q[AW-1:0]];
      assign dq_gate_ok[d] = !dq_pass[SEQ_W-1]; // see RULE10 see RULE12
      assign cq_gate_ok[d] = cq_head.kind != K_DREAD
                             || !cq_pass[SEQ_W-1]; // see RULE11 see RULE14
      assign dq_elig = dq_cnt_all[d] != '0 && dq_gate_ok[d]
                       && (cq_wp_q - cq_rp_q) != DEPTH_S;
      assign cq_push = state_q == TS_BUSY && src_dly_q && tgt_done[d];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          init_accept[d] <= 1'b0;
          init_retry[d]  <= 1'b0;
        end else begin
          init_accept[d] <= pw_push;
          init_retry[d]  <= init_valid[d] && !pw_push; // see RULE23
        end
      end

      // Every posted write is its own entry, in arrival order.
      always_ff @(posedge pclk) begin
        if (pw_push) begin
          pw_mem[pw_wp_q[AW-1:0]] <= init_txn[d]; // see RULE2 see RULE16
        end
        if (dq_push) begin
          dq_mem[dq_wp_q[AW-1:0]] <= init_txn[d]; // see RULE23
          dq_tag[dq_wp_q[AW-1:0]] <= pw_wp_q;
        end
        if (cq_push) begin
          cq_mem[cq_wp_q[AW-1:0]] <= '{kind: tgt_txn[d].kind,
                                      data: tgt_rdata[d],
                                      par:  tgt_rpar[d]}; // see RULE1
          cq_tag[cq_wp_q[AW-1:0]] <= pw_wp_all[1-d];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pw_wp_q <= '0;
          dq_wp_q <= '0;
          cq_wp_q <= '0;
        end else begin
          pw_wp_q <= pw_wp_q + SEQ_W'(pw_push);
          dq_wp_q <= dq_wp_q + SEQ_W'(dq_push);
          cq_wp_q <= cq_wp_q + SEQ_W'(cq_push);
        end
      end

      // Target side: a retry leaves the head queued and reopens arbitration.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          state_q      <= TS_IDLE;
          src_dly_q    <= 1'b0;
          rr_q         <= 1'b0;
          tgt_valid[d] <= 1'b0;
          tgt_txn[d]   <= '0;
          pw_rp_q      <= '0;
          dq_rp_q      <= '0;
        end else begin
          case (state_q)
            TS_IDLE: begin
              if (pw_has && (!rr_q || !dq_elig)) begin // see RULE13
                state_q      <= TS_BUSY;
                src_dly_q    <= 1'b0;
                tgt_valid[d] <= 1'b1;
                tgt_txn[d]   <= pw_mem[pw_rp_q[AW-1:0]]; // see RULE9
              end else if (dq_elig) begin
                state_q      <= TS_BUSY;
                src_dly_q    <= 1'b1;
                tgt_valid[d] <= 1'b1;
                tgt_txn[d]   <= dq_head; // see RULE14
              end
            end
            TS_BUSY: begin
              if (tgt_done[d]) begin // see RULE3
                state_q      <= TS_IDLE;
                tgt_valid[d] <= 1'b0;
                rr_q         <= !src_dly_q; // see RULE24
                if (src_dly_q) begin
                  dq_rp_q <= dq_rp_q + 1'b1;
                end else begin
                  pw_rp_q <= pw_rp_q + 1'b1;
                end
              end else if (tgt_retry[d]) begin // see RULE3 see RULE4
                state_q      <= TS_IDLE;
                tgt_valid[d] <= 1'b0;
              end
            end
            default: begin
              state_q      <= TS_IDLE;
              tgt_valid[d] <= 1'b0;
            end
          endcase
        end
      end

      // Completions return in order to the initiator bus.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ret_valid[d] <= 1'b0;
          ret_cpl[d]   <= '0;
          cq_rp_q      <= '0;
        end else if (ret_valid[d]) begin
          if (ret_ack[d]) begin
            ret_valid[d] <= 1'b0;
            cq_rp_q      <= cq_rp_q + 1'b1;
          end
        end else if (cq_wp_q != cq_rp_q && cq_gate_ok[d]) begin // see RULE11
          ret_valid[d] <= 1'b1;
          ret_cpl[d]   <= cq_head; // see RULE1 see RULE16
        end
      end
    end
  endgenerate

  property p_pri_devsel;
    @(posedge pclk) disable iff (!presetn)
      pa_err[0] && ctrl_q[CTRL_PRI_RESP] |=> primary_device_select_n;
  endproperty
  a_pri_devsel: assert property (p_pri_devsel) // see RULE18
    else $error("primary select asserted on address parity error");

  property p_sec_devsel;
    @(posedge pclk) disable iff (!presetn)
      pa_valid[1] && pa_hit[1] && !(pa_err[1] && ctrl_q[CTRL_SEC_RESP])
        |=> !secondary_device_select_n;
  endproperty
  a_sec_devsel: assert property (p_sec_devsel) // see RULE19
    else $error("secondary select missing for a claimable address");

  property p_det;
    @(posedge pclk) disable iff (!presetn)
      pa_err[0] && !(apb_wr && paddr == PSTAT_OFF) |=> pstat_q[STAT_DET];
  endproperty
  a_det: assert property (p_det) // see RULE20
    else $error("primary detected parity bit not set");

  property p_serr;
    @(posedge pclk) disable iff (!presetn)
      pa_err[0] && ctrl_q[CTRL_SERR_EN] && ctrl_q[CTRL_PRI_RESP]
        |=> !primary_system_error_n && pstat_q[STAT_SSE];
  endproperty
  a_serr: assert property (p_serr) // see RULE21
    else $error("system error not signalled for primary parity error");

  property p_serr_s;
    @(posedge pclk) disable iff (!presetn)
      pa_err[1] && ctrl_q[CTRL_SERR_EN] && ctrl_q[CTRL_SEC_RESP]
        |=> !primary_system_error_n && pstat_q[STAT_SSE];
  endproperty
  a_serr_s: assert property (p_serr_s) // see RULE22
    else $error("system error not signalled for secondary parity error");

  property p_serr_sec;
    @(posedge pclk) disable iff (!presetn)
      !primary_system_error_n |-> $past(pa_err[1] || pa_err[0]);
  endproperty
  a_serr_sec: assert property (p_serr_sec) // see RULE22
    else $error("system error without an address parity error");

  property p_retry;
    @(posedge pclk) disable iff (!presetn)
      init_valid[0] && init_txn[0].kind != K_POSTED |=> init_retry[0];
  endproperty
  a_retry: assert property (p_retry) // see RULE23
    else $error("delayed request not answered with retry");

  property p_accept;
    @(posedge pclk) disable iff (!presetn)
      init_valid[1] && init_txn[1].kind == K_POSTED
        && pw_cnt_all[1] != DEPTH_S
        |=> init_accept[1];
  endproperty
  a_accept: assert property (p_accept) // see RULE8
    else $error("posted write refused with room in queue");

  property p_dly_order;
    @(posedge pclk) disable iff (!presetn)
      $rose(tgt_valid[0]) && tgt_txn[0].kind != K_POSTED
        |-> $past(dq_gate_ok[0]);
  endproperty
  a_dly_order: assert property (p_dly_order) // see RULE10
    else $error("delayed request passed an earlier posted write");

  property p_ret_order;
    @(posedge pclk) disable iff (!presetn)
      $rose(ret_valid[0]) |-> $past(cq_gate_ok[0]);
  endproperty
  a_ret_order: assert property (p_ret_order) // see RULE11
    else $error("read completion passed an earlier posted write");

  property p_rr;
    @(posedge pclk) disable iff (!presetn)
      tgt_valid[0] && tgt_done[0] && tgt_txn[0].kind == K_POSTED
        |=> rr_all[0];
  endproperty
  a_rr: assert property (p_rr) // see RULE24
    else $error("priority did not move to the delayed queue");

  c_pw_done: cover property (@(posedge pclk) disable iff (!presetn)
    tgt_valid[0] && tgt_done[0] && tgt_txn[0].kind == K_POSTED);
  c_ret: cover property (@(posedge pclk) disable iff (!presetn)
    ret_valid[1] && ret_ack[1]);
  c_serr: cover property (@(posedge pclk) disable iff (!presetn)
    !primary_system_error_n);
  c_retry_tgt: cover property (@(posedge pclk) disable iff (!presetn)
    tgt_valid[0] && tgt_retry[0]);

endmodule

// ### bb_far_model.sv
`timescale 1ns/1ps
module bb_far_model
  import bb_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] hold,
  input  wire logic [1:0] slow,
  input  wire logic [1:0] rty,
  input  wire logic [1:0] tgt_valid,
  input  bb_txn_s   [1:0] tgt_txn,
  output logic [1:0]      tgt_done = 2'h0,
  output logic [1:0]      tgt_retry = 2'h0,
  output logic [1:0][31:0] tgt_rdata = '0,
  output logic [1:0]      tgt_rpar = 2'h0,
  input  wire logic [1:0] ret_valid,
  output logic [1:0]      ret_ack = 2'h0
);
  logic [1:0][1:0] cnt_q = '0;
  // Each direction answers on its own, never waiting on the other.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= '0;
      tgt_done  <= 2'h0;
      tgt_retry <= 2'h0;
      tgt_rdata <= '0;
      tgt_rpar  <= 2'h0;
      ret_ack   <= 2'h0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        tgt_done[d]  <= 1'b0;
        tgt_retry[d] <= 1'b0;
        tgt_rdata[d] <= ~tgt_rdata[d];
        tgt_rpar[d]  <= ~tgt_rpar[d];
        ret_ack[d]   <= ret_valid[d] & ~ret_ack[d];
        if (tgt_valid[d] && !tgt_done[d] && !tgt_retry[d] && !hold[d]) begin
          if (cnt_q[d] < {slow[d], slow[d]}) begin
            cnt_q[d] <= cnt_q[d] + 2'h1;
          end else begin
            cnt_q[d]     <= 2'h0;
            tgt_done[d]  <= ~rty[d];
            tgt_retry[d] <= rty[d];
            tgt_rdata[d] <= ~tgt_txn[d].addr;
            tgt_rpar[d]  <= tgt_txn[d].addr[0];
          end
        end
      end
    end
  end
endmodule

// ### tb_bridge_ordering_and_addr_parity.sv
`timescale 1ns/1ps
module tb_bridge_ordering_and_addr_parity
  import bb_pkg::*;
;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready, pslverr, dsel_p_n, dsel_s_n, serr_n;
  logic [1:0]        init_valid = '0;
  bb_txn_s [1:0]     init_txn = '0;
  logic [1:0]        init_accept, init_retry, tgt_valid, tgt_done, tgt_retry;
  bb_txn_s [1:0]     tgt_txn;
  logic [1:0][31:0]  tgt_rdata;
  logic [1:0]        tgt_rpar, ret_valid, ret_ack;
  bb_cpl_s [1:0]     ret_cpl;
  logic [1:0]        pa_valid = '0, pa_par = '0, pa_hit = '0;
  logic [1:0][31:0]  pa_ad = '0;
  logic [1:0][3:0]   pa_cbe = '0;
  logic [1:0]        hold = '0, slow = '0, rty = '0;
  logic [1:0]        init_prev = '0, pa_prev = '0;
  int                mismatches = 0, checked = 0, cycles = 0, seed = 70;
  int                pissued[2] = '{0, 0}, pdone[2] = '{0, 0};
  bb_txn_s           pq[2][$], dq[2][$];
  int                nq[2][$];
  bb_cpl_s           rq[2][$];
  logic              ans_q[2][$];
  logic [33:0]       apb_q[$];
  logic [2:0]        par_q[$];
  bb_kind_e          ks[3] = '{K_POSTED, K_DREAD, K_DWRITE};

  bb_bridge_core #(.DEPTH(4)) i_bb_bridge_core (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .init_valid, .init_txn, .init_accept, .init_retry,
    .tgt_valid, .tgt_txn, .tgt_done, .tgt_retry, .tgt_rdata, .tgt_rpar,
    .ret_valid, .ret_cpl, .ret_ack, .pa_valid, .pa_ad, .pa_cbe, .pa_par,
    .pa_hit, .primary_device_select_n(dsel_p_n),
    .secondary_device_select_n(dsel_s_n), .primary_system_error_n(serr_n)
  );
  bb_far_model i_bb_far_model (
    .pclk, .presetn, .hold, .slow, .rty, .tgt_valid, .tgt_txn, .tgt_done,
    .tgt_retry, .tgt_rdata, .tgt_rpar, .ret_valid, .ret_ack
  );

  always #10 pclk = ~pclk;

  task automatic conclude();
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string w, logic [127:0] s, logic [127:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // Results are compared mid-cycle, once the edge's updates have landed.
  always @(negedge pclk) begin
    logic [33:0] a;
    logic [2:0]  p;
    bb_cpl_s     c;
    if (pready) begin
      a = apb_q.pop_front();
      chk("pslverr", 128'(pslverr), 128'(a[32]));
      if (a[33]) chk("prdata", 128'(prdata), 128'(a[31:0]));
    end
    for (int d = 0; d < 2; d++) begin
      if (init_prev[d]) begin
        chk("retry", 128'(init_retry[d]), 128'(ans_q[d][0]));
        chk("accept", 128'(init_accept[d]),
            128'(!ans_q[d].pop_front()));
      end
      if (tgt_valid[d] && tgt_done[d] && tgt_txn[d].kind == K_POSTED) begin
        chk("posted", 128'(tgt_txn[d]), 128'(pq[d].pop_front()));
        pdone[d]++;
      end else if (tgt_valid[d] && tgt_done[d]) begin
        chk("delayed", 128'(tgt_txn[d]), 128'(dq[d].pop_front()));
        chk("pushed", 128'(pdone[d] >= nq[d].pop_front()), 128'(1));
      end
      if (ret_valid[d] && ret_ack[d]) begin
        c = rq[d].pop_front();
        chk("kind", 128'(ret_cpl[d].kind), 128'(c.kind));
        if (c.kind == K_DREAD) begin
          chk("rdata", 128'({ret_cpl[d].data, ret_cpl[d].par}), 128'({c.data, c.par}));
          chk("pulled", 128'(pq[1-d].size()), 128'(0));
        end
      end
    end
    if (pa_prev != 2'h0) begin
      p = par_q.pop_front();
      chk("select", 128'({dsel_p_n, dsel_s_n, serr_n}), 128'(p));
    end
    init_prev = init_valid;
    pa_prev = pa_valid;
  end

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd,
                     logic [31:0] e, logic err);
    apb_q.push_back({~wr, err, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic send(logic [1:0] m, bb_kind_e k, logic full);
    bb_txn_s t;
    for (int d = 0; d < 2; d++) begin
      if (m[d]) begin
        t = {k, $random(seed), $random(seed), 4'($random(seed)), 1'b0};
        t.par = ^{t.addr, t.data, t.be};
        init_txn[d] <= t;
        init_valid[d] <= 1'b1;
        ans_q[d].push_back(full || k != K_POSTED);
        if (!full && k == K_POSTED) begin
          pq[d].push_back(t);
          pissued[d]++;
        end else if (!full) begin
          dq[d].push_back(t);
          nq[d].push_back(pissued[d]);
          rq[d].push_back('{k, ~t.addr, t.addr[0]});
        end
      end
    end
    @(posedge pclk);
    init_valid <= 2'h0;
    @(posedge pclk);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (pq[0].size() + pq[1].size() + dq[0].size() + dq[1].size()
           + rq[0].size() + rq[1].size() != 0 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk("drained", 128'(n < 500), 128'(1));
    repeat (4) @(posedge pclk);
  endtask

  task automatic addr_par(int b, logic [2:0] c, logic bad);
    logic        rsp, h, hit_n;
    logic [31:0] ad;
    logic [3:0]  cb;
    rsp = (b == 0) ? c[CTRL_PRI_RESP] : c[CTRL_SEC_RESP];
    ad = $random(seed);
    cb = 4'($random(seed));
    h = 1'($random(seed));
    hit_n = ~h | (bad & rsp);
    apb(1'b1, CTRL_OFF, {29'h0, c}, 0, 1'b0);
    pa_ad[b] <= ad;
    pa_cbe[b] <= cb;
    pa_par[b] <= (^{ad, cb}) ^ bad;
    pa_hit[b] <= h;
    pa_valid[b] <= 1'b1;
    par_q.push_back({b == 1 | hit_n, b == 0 | hit_n,
                     ~(bad & rsp & c[CTRL_SERR_EN])});
    @(posedge pclk);
    pa_valid <= 2'h0;
    @(posedge pclk);
    apb(1'b0, PSTAT_OFF, 0, {30'h0, bad & rsp & c[CTRL_SERR_EN],
                             bad & b == 0}, 1'b0);
    apb(1'b0, SSTAT_OFF, 0, {31'h0, bad & b == 1}, 1'b0);
    apb(1'b1, PSTAT_OFF, 32'h3, 0, 1'b0);
    apb(1'b1, SSTAT_OFF, 32'h1, 0, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_OFF, 0, 0, 1'b0);
    apb(1'b0, QSTAT_OFF, 0, 0, 1'b0);
    apb(1'b1, CTRL_OFF, 32'h5, 0, 1'b0);
    apb(1'b0, CTRL_OFF, 0, 32'h5, 1'b0);
    apb(1'b0, 12'h010, 0, 0, 1'b1);
    apb(1'b1, 12'h010, 32'hffffffff, 0, 1'b1);
    // Stall one direction, fill it, then let it drain through retries.
    hold <= 2'h1;
    repeat (4) send(2'h1, K_POSTED, 1'b0);
    send(2'h1, K_POSTED, 1'b1);
    send(2'h1, K_DREAD, 1'b0);
    send(2'h1, K_DWRITE, 1'b0);
    apb(1'b0, QSTAT_OFF, 0, 32'h00040002, 1'b0);
    rty <= 2'h1;
    hold <= 2'h0;
    slow <= 2'h1;
    repeat (12) @(posedge pclk);
    rty <= 2'h0;
    drain();
    // A read completion must wait for older writes heading its way.
    hold <= 2'h2;
    repeat (2) send(2'h2, K_POSTED, 1'b0);
    send(2'h1, K_DREAD, 1'b0);
    repeat (30) @(posedge pclk);
    hold <= 2'h0;
    drain();
    repeat (3) send(2'h3, K_POSTED, 1'b0);
    send(2'h2, K_DREAD, 1'b0);
    send(2'h2, K_DWRITE, 1'b0);
    drain();
    hold <= 2'h1;
    send(2'h1, K_DREAD, 1'b0);
    send(2'h1, K_POSTED, 1'b0);
    hold <= 2'h0;
    drain();
    repeat (6) begin
      slow <= 2'($random(seed));
      repeat (3) send(2'h1, ks[$unsigned($random(seed)) % 3], 1'b0);
      drain();
    end
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 8; c++) begin
        for (int e = 0; e < 2; e++) begin
          addr_par(b, 3'(c), e[0]);
        end
      end
    end
    conclude();
  end
endmodule
